// >>> src/ple_defs.vh
// constants shared by the programmable logic equation unit
`ifndef PLE_DEFS_VH
`define PLE_DEFS_VH

// ==========================================================
// sizes
`define PLE_NUM_EQ 32
`define PLE_NUM_AUX 16
`define PLE_NUM_SHARED 5
`define PLE_NUM_FUNC 16
`define PLE_NUM_RELAY 8
`define PLE_NUM_PEER 160
`define PLE_NUM_EXT 64
`define PLE_SRC_W 256
`define PLE_DLY_W 16

// ==========================================================
// command source space (8-bit selector)
`define PLE_SRC_EQ_BASE 0
`define PLE_SRC_PEER_BASE 32
`define PLE_SRC_EXT_BASE 192

// ==========================================================
// sign settings
`define PLE_SIGN_PASS 2'h0
`define PLE_SIGN_NOT 2'h1
`define PLE_SIGN_ZERO 2'h2
`define PLE_SIGN_ONE 2'h3

// ==========================================================
// operators
`define PLE_OP_AND 3'h0
`define PLE_OP_NAND 3'h1
`define PLE_OP_OR 3'h2
`define PLE_OP_NOR 3'h3
`define PLE_OP_XOR 3'h4
`define PLE_OP_EQU 3'h5

// ==========================================================
// destination categories
`define PLE_DEST_NONE 2'h0
`define PLE_DEST_FLAG 2'h1
`define PLE_DEST_FUNC 2'h2
`define PLE_DEST_RELAY 2'h3
// flag index at this and the four above it selects a unit-shared flag
`define PLE_FLAG_SHARED_BASE 5'h10

// ==========================================================
// register map (byte addresses)
`define PLE_EQ_REGION_END 12'h200
`define PLE_EQ_WORD_SEL 2'h0
`define PLE_EQ_WORD_MODE 2'h1
`define PLE_EQ_WORD_DLY 2'h2
`define PLE_EQ_WORD_STAT 2'h3
`define PLE_REG_CTRL 12'h200
`define PLE_REG_FLAGS 12'h204
`define PLE_REG_FUNCS 12'h208
`define PLE_REG_RELAYS 12'h20c

// ==========================================================
// field layouts
`define PLE_F_SEL1 7:0
`define PLE_F_SEL2 15:8
`define PLE_F_SEL3 23:16
`define PLE_F_SIGN1 1:0
`define PLE_F_SIGN2 3:2
`define PLE_F_SIGN3 5:4
`define PLE_F_OP1 8:6
`define PLE_F_OP2 11:9
`define PLE_F_DCAT 13:12
`define PLE_F_DIDX 20:16
`define PLE_F_DLY_ON 15:0
`define PLE_F_DLY_OFF 31:16
`define PLE_F_MODE 1:0
`define PLE_SEL_W 24
`define PLE_MODE_W 21

// ==========================================================
// reset values
`define PLE_SEL_RST 24'h000000
`define PLE_MODE_RST 21'h000000
`define PLE_DLY_RST 32'h00000000
`define PLE_APP_RST 2'h0

// ==========================================================
// relays usable per application mode
`define PLE_RELAYS_MODE0 4'h2
`define PLE_RELAYS_MODE1 4'h4
`define PLE_RELAYS_MODE2 4'h6
`define PLE_RELAYS_MODE3 4'h8

// ==========================================================
// timing
`define PLE_CLK_PERIOD_NS 25
`define PLE_TICK_NS 1000000

`endif

// >>> src/ple_logic_equations.v
// programmable three-input logic equation unit with apb configuration
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "ple_defs.vh"

// How it works
// - two operators chain three signed inputs
// - pass sign forwards input unchanged
// - invert sign feeds complemented input
// - zero sign forces false path
// - one sign forces true path
// - six operators with standard truth tables
// - separate assertion and release delays
// - results numbered, selectable as inputs
// - sixteen auxiliary flags driven as outputs only, not selectable as inputs
// - five shared flags sent over CAN
// - peer shared flags received as inputs
// - results routed to flag, function, relay
// - usable relays follow application mode
module ple_logic_equations #(
    parameter TICK_CYCLES = `PLE_TICK_NS / `PLE_CLK_PERIOD_NS,
    parameter DLY_W = `PLE_DLY_W
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [`PLE_NUM_EXT-1:0] cmd_in,
    input wire [`PLE_NUM_PEER-1:0] peer_flags,
    output reg [`PLE_NUM_AUX-1:0] aux_flags,
    output reg [`PLE_NUM_SHARED-1:0] shared_flags,
    output reg shared_tx_req,
    output reg [`PLE_NUM_FUNC-1:0] func_out,
    output reg [`PLE_NUM_RELAY-1:0] relay_out
);

    localparam NEQ = `PLE_NUM_EQ;
    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

    // ==========================================================
    // helpers
    function sign_fn;
        input val;
        input [1:0] sgn;
        begin
            case (sgn)
                `PLE_SIGN_PASS: sign_fn = val;
                `PLE_SIGN_NOT: sign_fn = ~val;
                `PLE_SIGN_ZERO: sign_fn = 1'b0;
                default: sign_fn = 1'b1;
            endcase
        end
    endfunction

    function op_fn;
        input a;
        input b;
        input [2:0] op;
        begin
            case (op)
                `PLE_OP_NAND: op_fn = ~(a & b);
                `PLE_OP_OR: op_fn = a | b;
                `PLE_OP_NOR: op_fn = ~(a | b);
                `PLE_OP_XOR: op_fn = a ^ b;
                `PLE_OP_EQU: op_fn = ~(a ^ b);
                default: op_fn = a & b;
            endcase
        end
    endfunction

    function [3:0] relay_limit;
        input [1:0] mode;
        begin
            case (mode)
                2'h0: relay_limit = `PLE_RELAYS_MODE0;
                2'h1: relay_limit = `PLE_RELAYS_MODE1;
                2'h2: relay_limit = `PLE_RELAYS_MODE2;
                default: relay_limit = `PLE_RELAYS_MODE3;
            endcase
        end
    endfunction

    // ==========================================================
    // state
    reg [`PLE_SEL_W-1:0] cfg_sel [0:NEQ-1];
    reg [`PLE_MODE_W-1:0] cfg_mode [0:NEQ-1];
    reg [31:0] cfg_dly [0:NEQ-1];
    reg [DLY_W-1:0] dly_cnt [0:NEQ-1];
    reg [NEQ-1:0] eq_res;
    reg [NEQ-1:0] raw_res;
    reg [1:0] app_mode;
    reg [31:0] tick_cnt;
    reg tick;
    reg [`PLE_NUM_EXT-1:0] ext_meta;
    reg [`PLE_NUM_EXT-1:0] ext_sync;
    reg [`PLE_NUM_PEER-1:0] peer_meta;
    reg [`PLE_NUM_PEER-1:0] peer_sync;
    reg [`PLE_NUM_AUX-1:0] next_aux;
    reg [`PLE_NUM_SHARED-1:0] next_shared;
    reg [`PLE_NUM_FUNC-1:0] next_func;
    reg [`PLE_NUM_RELAY-1:0] next_relay;
    reg [31:0] next_prdata;
    reg next_pslverr;
    reg [NEQ-1:0] dly_met;
    // one loop counter per process, so no variable has two drivers; e and i serve the routing
    integer e_eval;
    integer e;
    integer i;
    integer e_cfg;
    integer e_dly;
    integer e_upd;

    // every selectable source, equation results first
    wire [`PLE_SRC_W-1:0] src_vec = {ext_sync, peer_sync, eq_res};

    wire [4:0] eq_idx = paddr[8:4];
    wire [1:0] eq_word = paddr[3:2];
    wire in_eq = paddr < `PLE_EQ_REGION_END;
    wire apb_done = psel & penable & pready;

    // ==========================================================
    // combinational evaluation of all equations
    always @* begin
        raw_res = {NEQ{1'b0}};
        for (e_eval = 0; e_eval < NEQ; e_eval = e_eval + 1) begin
            raw_res[e_eval] = op_fn(
                op_fn(sign_fn(src_vec[cfg_sel[e_eval][`PLE_F_SEL1]], cfg_mode[e_eval][`PLE_F_SIGN1]),
                      sign_fn(src_vec[cfg_sel[e_eval][`PLE_F_SEL2]], cfg_mode[e_eval][`PLE_F_SIGN2]),
                      cfg_mode[e_eval][`PLE_F_OP1]),
                sign_fn(src_vec[cfg_sel[e_eval][`PLE_F_SEL3]], cfg_mode[e_eval][`PLE_F_SIGN3]),
                cfg_mode[e_eval][`PLE_F_OP2]);
        end
    end

    // ==========================================================
    // delay reached: on delay while heading true, off delay while heading false
    always @* begin
        dly_met = {NEQ{1'b0}};
        for (e_dly = 0; e_dly < NEQ; e_dly = e_dly + 1) begin
            if (raw_res[e_dly])
                dly_met[e_dly] = dly_cnt[e_dly] >= cfg_dly[e_dly][`PLE_F_DLY_ON];
            else
                dly_met[e_dly] = dly_cnt[e_dly] >= cfg_dly[e_dly][`PLE_F_DLY_OFF];
        end
    end

    // ==========================================================
    // routing of results to destinations; several equations on one target are or-ed
    always @* begin
        next_aux = {`PLE_NUM_AUX{1'b0}};
        next_shared = {`PLE_NUM_SHARED{1'b0}};
        next_func = {`PLE_NUM_FUNC{1'b0}};
        next_relay = {`PLE_NUM_RELAY{1'b0}};
        for (e = 0; e < NEQ; e = e + 1) begin
            for (i = 0; i < `PLE_NUM_AUX; i = i + 1) begin
                if (cfg_mode[e][`PLE_F_DCAT] == `PLE_DEST_FLAG && cfg_mode[e][`PLE_F_DIDX] == i[4:0])
                    next_aux[i] = next_aux[i] | eq_res[e];
                if (cfg_mode[e][`PLE_F_DCAT] == `PLE_DEST_FUNC && cfg_mode[e][`PLE_F_DIDX] == i[4:0])
                    next_func[i] = next_func[i] | eq_res[e];
            end
            for (i = 0; i < `PLE_NUM_SHARED; i = i + 1) begin
                if (cfg_mode[e][`PLE_F_DCAT] == `PLE_DEST_FLAG &&
                    cfg_mode[e][`PLE_F_DIDX] == `PLE_FLAG_SHARED_BASE + i[4:0])
                    next_shared[i] = next_shared[i] | eq_res[e];
            end
            for (i = 0; i < `PLE_NUM_RELAY; i = i + 1) begin
                // relays beyond the mode's allowance stay off
                if (cfg_mode[e][`PLE_F_DCAT] == `PLE_DEST_RELAY && cfg_mode[e][`PLE_F_DIDX] == i[4:0] &&
                    i[3:0] < relay_limit(app_mode))
                    next_relay[i] = next_relay[i] | eq_res[e];
            end
        end
    end

    // ==========================================================
    // apb read mux, decoded in setup so the answer is ready in access
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (in_eq) begin
            case (eq_word)
                `PLE_EQ_WORD_SEL: next_prdata = {8'h00, cfg_sel[eq_idx]};
                `PLE_EQ_WORD_MODE: next_prdata = {11'h000, cfg_mode[eq_idx]};
                `PLE_EQ_WORD_DLY: next_prdata = cfg_dly[eq_idx];
                // status word: bit 1 raw condition, bit 0 delayed result
                default: next_prdata = {30'h00000000, raw_res[eq_idx], eq_res[eq_idx]};
            endcase
        end else begin
            case (paddr)
                `PLE_REG_CTRL: next_prdata = {30'h00000000, app_mode};
                `PLE_REG_FLAGS: next_prdata = {11'h000, shared_flags, aux_flags};
                `PLE_REG_FUNCS: next_prdata = {16'h0000, func_out};
                `PLE_REG_RELAYS: next_prdata = {24'h000000, relay_out};
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // apb slave: no wait states, writes land at the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            app_mode <= `PLE_APP_RST;
            for (e_cfg = 0; e_cfg < NEQ; e_cfg = e_cfg + 1) begin
                cfg_sel[e_cfg] <= `PLE_SEL_RST;
                cfg_mode[e_cfg] <= `PLE_MODE_RST;
                cfg_dly[e_cfg] <= `PLE_DLY_RST;
            end
        end else if (ce) begin
            if (apb_done) begin
                // answer stands for the access cycle only, so no stale error lingers
                pready <= 1'b0;
                prdata <= 32'h00000000;
                pslverr <= 1'b0;
                if (pwrite && !pslverr) begin
                    if (in_eq) begin
                        case (eq_word)
                            `PLE_EQ_WORD_SEL: cfg_sel[eq_idx] <= pwdata[`PLE_SEL_W-1:0];
                            `PLE_EQ_WORD_MODE: cfg_mode[eq_idx] <= pwdata[`PLE_MODE_W-1:0];
                            `PLE_EQ_WORD_DLY: cfg_dly[eq_idx] <= pwdata;
                            default: ;
                        endcase
                    end else if (paddr == `PLE_REG_CTRL) begin
                        app_mode <= pwdata[`PLE_F_MODE];
                    end
                end
            end else if (psel && !penable) begin
                pready <= 1'b1;
                prdata <= pwrite ? 32'h00000000 : next_prdata;
                pslverr <= next_pslverr;
            end
        end
    end

    // ==========================================================
    // input synchronisers, evaluation tick, delays and outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta <= {`PLE_NUM_EXT{1'b0}};
            ext_sync <= {`PLE_NUM_EXT{1'b0}};
            peer_meta <= {`PLE_NUM_PEER{1'b0}};
            peer_sync <= {`PLE_NUM_PEER{1'b0}};
            tick_cnt <= 32'h00000000;
            tick <= 1'b0;
            eq_res <= {NEQ{1'b0}};
            aux_flags <= {`PLE_NUM_AUX{1'b0}};
            shared_flags <= {`PLE_NUM_SHARED{1'b0}};
            shared_tx_req <= 1'b0;
            func_out <= {`PLE_NUM_FUNC{1'b0}};
            relay_out <= {`PLE_NUM_RELAY{1'b0}};
            for (e_upd = 0; e_upd < NEQ; e_upd = e_upd + 1)
                dly_cnt[e_upd] <= {DLY_W{1'b0}};
        end else if (ce) begin
            // two flops per asynchronous input; only the second one is read
            ext_meta <= cmd_in;
            ext_sync <= ext_meta;
            peer_meta <= peer_flags;
            peer_sync <= peer_meta;
            // free-running tick divider
            if (tick_cnt == TICK_LAST) begin
                tick_cnt <= 32'h00000000;
                tick <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 32'h00000001;
                tick <= 1'b0;
            end
            // a pending change must hold through its delay, else it restarts
            if (tick) begin
                for (e_upd = 0; e_upd < NEQ; e_upd = e_upd + 1) begin
                    if (raw_res[e_upd] != eq_res[e_upd]) begin
                        if (dly_met[e_upd]) begin
                            eq_res[e_upd] <= raw_res[e_upd];
                            dly_cnt[e_upd] <= {DLY_W{1'b0}};
                        end else begin
                            dly_cnt[e_upd] <= dly_cnt[e_upd] + {{(DLY_W-1){1'b0}}, 1'b1};
                        end
                    end else begin
                        dly_cnt[e_upd] <= {DLY_W{1'b0}};
                    end
                end
            end
            aux_flags <= next_aux;
            func_out <= next_func;
            relay_out <= next_relay;
            shared_flags <= next_shared;
            // ask the can side to send whenever a shared flag moves
            shared_tx_req <= next_shared != shared_flags;
        end
    end

endmodule // ple_logic_equations

// >>> tb/ple_checker.sv
// concurrent checks on the ports of the logic equation unit
`timescale 1ns/100ps
module ple_checker #(
    parameter TICK_CYCLES = 8
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire [15:0] aux_flags,
    input wire [15:0] func_out,
    input wire [4:0] shared_flags,
    input wire shared_tx_req,
    input wire [7:0] relay_out
);
// ==========================================================
// bus handshake
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
a_ready_after_setup: assert property (psel && !penable && ce && !pready |=> pready)
    else $error("no ready after setup");
a_ready_single: assert property (pready && ce |=> !pready) else $error("ready longer than one cycle");
a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
// ==========================================================
// equation outputs
a_tx_on_change: assert property ($changed(shared_flags) |-> ##[0:1] shared_tx_req)
    else $error("no transmit on flag change");
a_tx_pulse: assert property (shared_tx_req && $past(ce) |-> $changed(shared_flags))
    else $error("transmit without flag change");
a_reset_clears: assert property ($rose(presetn) |-> {aux_flags, func_out, shared_flags, relay_out} == 45'h0)
    else $error("outputs not cleared by reset");
// outputs move one clock after a tick or a config write, so two cycles running need a write
a_flags_tick_paced: assert property (ce && $changed({aux_flags, func_out}) |=>
    $stable({aux_flags, func_out}) || $past(pready && pwrite, 2) || $past(pready && pwrite, 3))
    else $error("outputs changed off tick");
c_write: cover property (pready && pwrite);
c_error: cover property (pslverr);
c_tx: cover property (shared_tx_req);
c_relay: cover property (relay_out != 8'h0);
endmodule // ple_checker

bind ple_logic_equations ple_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .aux_flags(aux_flags), .func_out(func_out),
    .shared_flags(shared_flags), .shared_tx_req(shared_tx_req), .relay_out(relay_out)
);

// >>> tb/ple_logic_equations_bench.sv
// self-checking bench for the logic equation unit
`timescale 1ns/100ps
module ple_logic_equations_bench;
localparam T = 8;
reg pclk, presetn, ce, psel, penable, pwrite;
reg [11:0] paddr;
reg [31:0] pwdata;
reg [63:0] cmd_in;
reg [159:0] peer_flags, pf;
wire [31:0] prdata;
wire pready, pslverr, shared_tx_req;
wire [15:0] aux_flags, func_out;
wire [4:0] shared_flags;
wire [7:0] relay_out;
integer err_total, checks_done, i, j, p, m, x, e;

ple_logic_equations #(.TICK_CYCLES(T)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_in(cmd_in), .peer_flags(peer_flags), .aux_flags(aux_flags), .shared_flags(shared_flags),
    .shared_tx_req(shared_tx_req), .func_out(func_out), .relay_out(relay_out)
);

// ==========================================================
// model and helpers
always #12.5 pclk = ~pclk;
function automatic integer sg(input integer v, input integer s);
    sg = s == 0 ? v : s == 1 ? !v : s == 2 ? 0 : 1;
endfunction
// operator codes pair up as plain and negated forms
function automatic integer opf(input integer a, input integer b, input integer o);
    opf = o < 2 ? (a & b) ^ o : o < 4 ? (a | b) ^ (o - 2) : (a ^ b) ^ (o - 4);
endfunction
task test_done;
    begin
        if (err_total == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    end
endtask
task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
// one transfer; waits on pready rather than assuming the latency
task apb(input [11:0] a, input w, input [31:0] d, input [31:0] er, input ee);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        if (!w) chk(prdata, er);
        chk({31'h0, pslverr}, {31'h0, ee});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
endtask
task tk(input integer n);
    repeat (n * T) @(posedge pclk);
endtask

// ==========================================================
// watchdog
initial begin
    repeat (20000) @(posedge pclk);
    err_total = err_total + 1;
    test_done;
end

// ==========================================================
// main sequence
initial begin
    pclk = 0; presetn = 0; ce = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; cmd_in = 0; peer_flags = 0; err_total = 0; checks_done = 0;
    x = $urandom(41095);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h004, 0, 0, 0, 0);
    apb(12'h008, 0, 0, 0, 0);
    apb(12'h210, 0, 0, 0, 1);
    apb(12'h214, 1, 32'hffffffff, 0, 1);
    apb(12'h000, 1, 32'h00c2c1c0, 0, 0);
    // every operator pair, random signs and command values
    for (i = 0; i < 36; i = i + 1) begin
        m = $urandom % 64;
        x = $urandom;
        cmd_in <= {$urandom, x};
        apb(12'h004, 1, 32'h2000 | (i / 6) << 9 | (i % 6) << 6 | m, 0, 0);
        tk(3);
        e = opf(opf(sg(x & 1, m & 3), sg(x >> 1 & 1, m >> 2 & 3), i % 6), sg(x >> 2 & 1, m >> 4 & 3), i / 6);
        chk(func_out, e);
        apb(12'h00c, 0, 0, e * 3, 0);
    end
    // assertion and release delays, condition follows command bit 0
    cmd_in <= 64'h0;
    apb(12'h004, 1, 32'h203c, 0, 0);
    apb(12'h008, 1, 32'h00020003, 0, 0);
    tk(5);
    chk(func_out, 0);
    cmd_in <= 64'h1;
    tk(3);
    chk(func_out, 0);
    tk(3);
    chk(func_out, 1);
    cmd_in <= 64'h0;
    tk(2);
    chk(func_out, 1);
    tk(3);
    chk(func_out, 0);
    // chain to relay 5, which the two narrower modes do not allow
    apb(12'h008, 1, 0, 0, 0);
    apb(12'h014, 1, 32'h00053000, 0, 0);
    cmd_in <= 64'h1;
    tk(4);
    chk(relay_out, 0);
    // modes 0 to 3 allow 2, 4, 6 and 8 relays
    for (j = 0; j < 4; j = j + 1) begin
        apb(12'h200, 1, j, 0, 0);
        apb(12'h20c, 0, 0, j > 1 ? 32'h20 : 0, 0);
        chk(relay_out, j > 1 ? 32'h20 : 0);
    end
    // peer flags into shared flags, chained on into aux flags
    apb(12'h030, 1, 32'h00020202, 0, 0);
    for (j = 0; j < 5; j = j + 1) begin
        p = $urandom % 160;
        pf = {$urandom, $urandom, $urandom, $urandom, $urandom};
        peer_flags <= pf;
        apb(12'h020, 1, (p + 32) * 32'h10101, 0, 0);
        apb(12'h024, 1, 32'h1000 | (j + 16) << 16, 0, 0);
        apb(12'h034, 1, 32'h1000 | (j * 3) << 16, 0, 0);
        tk(4);
        chk(shared_flags, {31'h0, pf[p]} << j);
        chk(aux_flags, {31'h0, pf[p]} << j * 3);
    end
    // clock enable low freezes every output, then the peer change passes on
    ce <= 1'b0;
    peer_flags <= ~pf;
    tk(4);
    chk(shared_flags, {31'h0, pf[p]} << 4);
    chk(aux_flags, {31'h0, pf[p]} << 12);
    ce <= 1'b1;
    tk(4);
    chk(shared_flags, {31'h0, ~pf[p]} << 4);
    chk(aux_flags, {31'h0, ~pf[p]} << 12);
    // reset in mid-run
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({aux_flags, func_out}, 0);
    apb(12'h024, 0, 0, 0, 0);
    apb(12'h200, 0, 0, 0, 0);
    test_done;
end
endmodule // ple_logic_equations_bench
